//--- src/tcs_cfg.svh
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
`define A_CTRL     8'h00
`define A_SENSOR   8'h04
`define A_ODCTRL   8'h08
`define A_ODTIME0  8'h0C
`define A_ODTIME1  8'h10
`define A_PORT     8'h14
`define A_SETPT    8'h18
`define A_ALARM    8'h1C
`define A_LIMIT    8'h20
`define A_PLIMIT   8'h24
`define A_TEMP12   8'h28
`define A_TEMP34   8'h2C
`define A_ANALOG   8'h30
`define A_PRESS    8'h34
`define A_AMP      8'h38
`define A_STATUS   8'h3C
`define A_IRQSTAT  8'h40
`define A_IRQMASK  8'h44
`define F_LEDOFF   2
`define F_LCDBIG   3
`define F_PAGE_LO  4
`define F_GAUGE    8
`define F_GAUGE_EN 9
`define F_GAUGE_CH 10
`define F_FIRE0    4
`define F_FIRE1    5
`define PORT_RST   8'hFF
`define CLK_MHZ    40
`define TICK_US    100
`define TICK_CYC   (`CLK_MHZ * `TICK_US)
`define SEC_MS     1000
`define HB_HZ      1
`define ERR_BAND   16'h0064
`define AMP_MAX    16'h7EF4
`define OV_MV      16'h3C8C
`define OC_MA      16'h02BC
`define AIN_FS_MV  26'h0002EE0
`define GAUGE_G0   16'h0001
`define GAUGE_G1   16'h000A
`endif

//--- src/tcs_pkg.sv
// types shared by the supervisor
package tcs_pkg;
  typedef enum logic [1:0] {
    OD_LOW   = 2'b00,
    OD_HIGH  = 2'b01,
    OD_PULSE = 2'b10,
    OD_RSV   = 2'b11
  } od_mode_type;
  typedef enum logic {
    GAUGE_A = 1'b0,
    GAUGE_B = 1'b1
  } gauge_type;
endpackage

//--- src/temp_controller_supervisor.sv
// supervisor, protection and indicator logic of the temperature controller, AHB-Lite slave
// Function
// - ch1/2 16-bit, ch3/4 12-bit auxiliary
// - software sensor type per channel
// - two 12-bit analogue inputs reported in millivolts
// - gauge pressure by selected type, millibar
// - open-drain static levels or timed one-shot
// - quasi-bidirectional port, write one to read
// - servo LED flashes, steady within 1K
// - per-servo alarm above alarm temperature
// - pressure alarm above programmed limit
// - heartbeat LED toggles at 1Hz
// - one control bit kills all LEDs
// - 8x2/16x4 display, eight pages, button steps
// - supply above 15.5V disables both servos
// - amp temps checked each second, 325K
// - servo over 700mA off within 250ms
// - programmable limit temperature disables servo
// - amp temperatures readable with servos off
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module temp_controller_supervisor #(
  parameter int SEC_TICKS = `SEC_MS * 1000 / `TICK_US,
  parameter int HB_TICKS  = `SEC_MS * 1000 / `TICK_US / (2 * `HB_HZ)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] temp1,
  input  wire logic [15:0] temp2,
  input  wire logic [11:0] temp3,
  input  wire logic [11:0] temp4,
  input  wire logic [11:0] ain1,
  input  wire logic [11:0] ain2,
  input  wire logic [15:0] amp_temp1,
  input  wire logic [15:0] amp_temp2,
  input  wire logic [15:0] servo_ma1,
  input  wire logic [15:0] servo_ma2,
  input  wire logic [15:0] supply_mv,
  input  wire logic        button_n,
  input  wire logic [7:0]  port_in,
  output logic      [7:0]  port_out,
  output logic      [7:0]  port_oe_n,
  output logic      [1:0]  od_out,
  output logic      [1:0]  od_oe_n,
  output logic      [3:0]  sensor_type,
  output logic      [1:0]  servo_en,
  output logic      [1:0]  led_servo,
  output logic      [1:0]  led_alarm,
  output logic             led_press,
  output logic             led_heart,
  output logic             lcd_large,
  output logic      [2:0]  lcd_page,
  output logic             irq
);
  localparam logic [11:0] TICK_LAST = 12'(`TICK_CYC - 1);
  function automatic logic [15:0] to_mv(input logic [11:0] code);
    logic [25:0] p;
    p = 26'(code) * `AIN_FS_MV;
    return {2'b00, p[25:12]};
  endfunction
  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction
  // bus slave: writes land in the data phase, reads take one wait state
  logic        wr_ph_r;
  logic        rd_ph_r;
  logic [7:0]  addr_r;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;
  wire         take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r  <= 1'b0;
      rd_ph_r  <= 1'b0;
      addr_r   <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_ph_r <= take & hwrite;
      rd_ph_r <= take & ~hwrite;
      if (take)
        addr_r <= {haddr[7:2], 2'b00};
      if (rd_ph_r)
        hrdata_r <= rd_mux;
    end
  end
  assign hreadyout = ~rd_ph_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  function automatic logic wr_at(input logic [7:0] a, input logic ph, input logic [7:0] ad);
    return ph && (ad == a);
  endfunction
  wire wr_ctrl = wr_at(`A_CTRL, wr_ph_r, addr_r);
  wire wr_od   = wr_at(`A_ODCTRL, wr_ph_r, addr_r);
  // pins from outside the clock domain
  logic [8:0] pin_s1_r;
  logic [8:0] pin_s2_r;
  logic       btn_d_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 9'h1FF;
      pin_s2_r <= 9'h1FF;
      btn_d_r  <= 1'b1;
    end else begin
      pin_s1_r <= {button_n, port_in};
      pin_s2_r <= pin_s1_r;
      btn_d_r  <= pin_s2_r[8];
    end
  end
  wire btn_press = btn_d_r & ~pin_s2_r[8];
  // 100us tick, one-second tick and heartbeat
  logic [11:0] pre_r;
  logic [15:0] sec_r;
  logic [15:0] hb_r;
  logic        hb_lvl_r;
  wire tick     = (pre_r == TICK_LAST);
  wire sec_tick = tick && (sec_r == 16'(SEC_TICKS - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r    <= 12'h000;
      sec_r    <= 16'h0000;
      hb_r     <= 16'h0000;
      hb_lvl_r <= 1'b0;
    end else begin
      pre_r <= tick ? 12'h000 : pre_r + 12'h001;
      if (tick) begin
        sec_r <= sec_tick ? 16'h0000 : sec_r + 16'h0001;
        hb_r  <= (hb_r == 16'(HB_TICKS - 1)) ? 16'h0000 : hb_r + 16'h0001;
        if (hb_r == 16'(HB_TICKS - 1))
          hb_lvl_r <= ~hb_lvl_r;
      end
    end
  end
  // control, setpoints and limits
  logic [10:0] ctrl_r;
  logic [3:0]  sensor_r;
  logic [31:0] setpt_r;
  logic [31:0] alarm_r;
  logic [31:0] limit_r;
  logic [31:0] plimit_r;
  logic [7:0]  port_r;
  logic [6:0]  imask_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r   <= 11'h000;
      sensor_r <= 4'h0;
      setpt_r  <= 32'h00000000;
      alarm_r  <= 32'hFFFFFFFF;
      limit_r  <= 32'hFFFFFFFF;
      plimit_r <= 32'hFFFFFFFF;
      port_r   <= `PORT_RST;
      imask_r  <= 7'h00;
    end else begin
      if (wr_ctrl)
        ctrl_r <= hwdata[10:0];
      else if (btn_press)
        ctrl_r[`F_PAGE_LO +: 3] <= ctrl_r[`F_PAGE_LO +: 3] + 3'h1;
      if (wr_at(`A_SENSOR, wr_ph_r, addr_r))
        sensor_r <= hwdata[3:0];
      if (wr_at(`A_SETPT, wr_ph_r, addr_r))
        setpt_r <= hwdata;
      if (wr_at(`A_ALARM, wr_ph_r, addr_r))
        alarm_r <= hwdata;
      if (wr_at(`A_LIMIT, wr_ph_r, addr_r))
        limit_r <= hwdata;
      if (wr_at(`A_PLIMIT, wr_ph_r, addr_r))
        plimit_r <= hwdata;
      if (wr_at(`A_PORT, wr_ph_r, addr_r))
        port_r <= hwdata[7:0];
      if (wr_at(`A_IRQMASK, wr_ph_r, addr_r))
        imask_r <= hwdata[6:0];
    end
  end
  assign sensor_type = sensor_r;
  assign port_out    = 8'h00;
  assign port_oe_n   = port_r;
  assign lcd_large   = ctrl_r[`F_LCDBIG];
  assign lcd_page    = ctrl_r[`F_PAGE_LO +: 3];
  // measurements; aux channels scaled up to the main channels' units
  wire [15:0] t3w  = {temp3, 4'h0};
  wire [15:0] t4w  = {temp4, 4'h0};
  wire [15:0] mv1  = to_mv(ain1);
  wire [15:0] mv2  = to_mv(ain2);
  wire [15:0] gmv  = ctrl_r[`F_GAUGE_CH] ? mv2 : mv1;
  wire [15:0] gain = (tcs_pkg::gauge_type'(ctrl_r[`F_GAUGE]) == tcs_pkg::GAUGE_B) ? `GAUGE_G1 : `GAUGE_G0;
  logic [31:0] press_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      press_r <= 32'h00000000;
    else
      press_r <= ctrl_r[`F_GAUGE_EN] ? gmv * gain : 32'h00000000;
  end
  // protection: {lim1, lim0, oc1, oc0, amp, ov}
  logic [5:0] fault_r;
  wire  [5:0] trip;
  assign trip[0] = supply_mv > `OV_MV;
  assign trip[1] = sec_tick && (amp_temp1 > `AMP_MAX || amp_temp2 > `AMP_MAX);
  // sampled each 100us tick, well inside the allowed reaction time
  assign trip[2] = tick && servo_ma1 > `OC_MA;
  assign trip[3] = tick && servo_ma2 > `OC_MA;
  assign trip[4] = temp1 > limit_r[15:0];
  assign trip[5] = temp2 > limit_r[31:16];
  wire [5:0] fclr = wr_ctrl ? {hwdata[1], hwdata[0], hwdata[1], hwdata[0], |hwdata[1:0], |hwdata[1:0]} : 6'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      fault_r <= 6'h00;
    else
      fault_r <= trip | (fault_r & ~fclr);
  end
  wire [1:0] off = {fault_r[5] | fault_r[3], fault_r[4] | fault_r[2]} | {2{|fault_r[1:0]}};
  assign servo_en = ctrl_r[1:0] & ~off;
  // open-drain outputs
  logic [3:0]  odctrl_r;
  logic [15:0] od_time_r [2];
  logic [15:0] od_cnt_r  [2];
  logic [1:0]  od_drv;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      odctrl_r <= 4'h1 | 4'h4;
      for (int i = 0; i < 2; i++) begin
        od_time_r[i] <= 16'h0000;
        od_cnt_r[i]  <= 16'h0000;
      end
    end else begin
      if (wr_od)
        odctrl_r <= hwdata[3:0];
      if (wr_at(`A_ODTIME0, wr_ph_r, addr_r))
        od_time_r[0] <= hwdata[15:0];
      if (wr_at(`A_ODTIME1, wr_ph_r, addr_r))
        od_time_r[1] <= hwdata[15:0];
      for (int i = 0; i < 2; i++) begin
        if (wr_od && hwdata[`F_FIRE0 + i])
          od_cnt_r[i] <= od_time_r[i];
        else if (tick && od_cnt_r[i] != 16'h0000)
          od_cnt_r[i] <= od_cnt_r[i] - 16'h0001;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case (tcs_pkg::od_mode_type'(odctrl_r[2*i +: 2]))
        tcs_pkg::OD_LOW:   od_drv[i] = 1'b1;
        tcs_pkg::OD_HIGH:  od_drv[i] = 1'b0;
        tcs_pkg::OD_PULSE: od_drv[i] = od_cnt_r[i] != 16'h0000;
        default:           od_drv[i] = 1'b0;
      endcase
    end
  end
  assign od_out  = 2'b00;
  assign od_oe_n = ~od_drv;
  // indicators
  logic [6:0] led_r;
  wire  [1:0] settled = {absdiff(temp2, setpt_r[31:16]) < `ERR_BAND, absdiff(temp1, setpt_r[15:0]) < `ERR_BAND};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      led_r <= 7'h00;
    else if (ctrl_r[`F_LEDOFF])
      led_r <= 7'h00;
    else begin
      for (int i = 0; i < 2; i++)
        led_r[i] <= servo_en[i] & (settled[i] | hb_lvl_r);
      led_r[2] <= temp1 > alarm_r[15:0];
      led_r[3] <= temp2 > alarm_r[31:16];
      led_r[4] <= ctrl_r[`F_GAUGE_EN] && press_r > plimit_r;
      led_r[5] <= hb_lvl_r;
      led_r[6] <= 1'b0;
    end
  end
  assign led_servo = led_r[1:0];
  assign led_alarm = led_r[3:2];
  assign led_press = led_r[4];
  assign led_heart = led_r[5];
  // interrupts: set wins over a write-one clear
  logic [6:0] istat_r;
  wire  [6:0] iset = {btn_press, trip};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      istat_r <= 7'h00;
    else if (wr_at(`A_IRQSTAT, wr_ph_r, addr_r))
      istat_r <= iset | (istat_r & ~hwdata[6:0]);
    else
      istat_r <= iset | istat_r;
  end
  assign irq = |(istat_r & imask_r);
  always_comb begin
    case (addr_r)
      `A_CTRL:    rd_mux = {21'h000000, ctrl_r};
      `A_SENSOR:  rd_mux = {28'h0000000, sensor_r};
      `A_ODCTRL:  rd_mux = {26'h0000000, od_drv, odctrl_r};
      `A_ODTIME0: rd_mux = {od_cnt_r[0], od_time_r[0]};
      `A_ODTIME1: rd_mux = {od_cnt_r[1], od_time_r[1]};
      `A_PORT:    rd_mux = {24'h000000, pin_s2_r[7:0]};
      `A_SETPT:   rd_mux = setpt_r;
      `A_ALARM:   rd_mux = alarm_r;
      `A_LIMIT:   rd_mux = limit_r;
      `A_PLIMIT:  rd_mux = plimit_r;
      `A_TEMP12:  rd_mux = {temp2, temp1};
      `A_TEMP34:  rd_mux = {t4w, t3w};
      `A_ANALOG:  rd_mux = {mv2, mv1};
      `A_PRESS:   rd_mux = press_r;
      `A_AMP:     rd_mux = {amp_temp2, amp_temp1};
      `A_STATUS:  rd_mux = {17'h00000, servo_en, led_r, fault_r};
      `A_IRQSTAT: rd_mux = {25'h0000000, istat_r};
      `A_IRQMASK: rd_mux = {25'h0000000, imask_r};
      default:    rd_mux = 32'h00000000;
    endcase
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ov;
    supply_mv > `OV_MV |=> servo_en == 2'b00;
  endproperty
  a_ov: assert property (p_ov) else $error("servo on during overvoltage");
  property p_amp;
    sec_tick && amp_temp2 > `AMP_MAX |=> servo_en == 2'b00 && fault_r[1];
  endproperty
  a_amp: assert property (p_amp) else $error("amp overtemp did not cut servos");
  property p_oc;
    tick && servo_ma1 > `OC_MA |=> !servo_en[0] && fault_r[2];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent servo left on");
  property p_lim;
    temp2 > limit_r[31:16] |=> !servo_en[1];
  endproperty
  a_lim: assert property (p_lim) else $error("servo above limit left on");
  property p_latch;
    fault_r[2] && !wr_ctrl |=> fault_r[2] && !servo_en[0];
  endproperty
  a_latch: assert property (p_latch) else $error("trip released without command");
  property p_alarm;
    !ctrl_r[`F_LEDOFF] && temp1 > alarm_r[15:0] ##1 !ctrl_r[`F_LEDOFF] |-> led_alarm[0];
  endproperty
  a_alarm: assert property (p_alarm) else $error("servo alarm missing");
  property p_press;
    led_press |-> $past(press_r > plimit_r) && $past(ctrl_r[`F_GAUGE_EN]);
  endproperty
  a_press: assert property (p_press) else $error("pressure alarm without cause");
  property p_fire;
    wr_od && hwdata[`F_FIRE1] && od_time_r[1] > 16'h0001 ##1 odctrl_r[3:2] == 2'b10 && !wr_od
      |-> od_oe_n[1] == 1'b0 [*2];
  endproperty
  a_fire: assert property (p_fire) else $error("one-shot not driven");
  property p_dark;
    ctrl_r[`F_LEDOFF] |=> {led_servo, led_alarm, led_press, led_heart} == 6'h00;
  endproperty
  a_dark: assert property (p_dark) else $error("indicator lit while disabled");
  property p_page;
    btn_press && !wr_ctrl |=> lcd_page == $past(lcd_page) + 3'h1;
  endproperty
  a_page: assert property (p_page) else $error("page did not step");
  property p_settle;
    servo_en[0] && settled[0] && !ctrl_r[`F_LEDOFF] ##1 servo_en[0] && !ctrl_r[`F_LEDOFF] |-> led_servo[0];
  endproperty
  a_settle: assert property (p_settle) else $error("settled servo LED not steady");
  c_ov:   cover property (trip[0] ##1 servo_en == 2'b00);
  c_fire: cover property (wr_od && hwdata[`F_FIRE1]);
  c_page: cover property (btn_press);
  c_irq:  cover property ($rose(irq));
endmodule

//--- bench/pin_model.sv
// pin model: quasi-bidirectional port pins with weak pull-up
`timescale 1ns/1ps
module pin_model (
  input  wire logic [7:0] port_oe_n,
  input  wire logic [7:0] ext_low,
  output logic      [7:0] port_in
);
  // a released pin reads high through the pull-up unless something outside sinks it
  assign port_in = port_oe_n & ~ext_low;
endmodule

//--- bench/temp_controller_supervisor_tb_top.sv
// self-checking bench of the temperature controller supervisor over AHB-Lite
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module temp_controller_supervisor_tb_top;
  localparam int SEC = 4;
  localparam int HB  = 2;
  localparam int TK  = `TICK_CYC;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] temp1 = 16'h7530;
  logic [15:0] temp2 = 16'h7594;
  logic [11:0] temp3 = 12'h123;
  logic [11:0] temp4 = 12'h456;
  logic [11:0] ain1 = 12'hFFF;
  logic [11:0] ain2 = 12'h200;
  logic [15:0] amp_temp1 = 16'h7530;
  logic [15:0] amp_temp2 = 16'h7530;
  logic [15:0] servo_ma1 = 16'h0000;
  logic [15:0] servo_ma2 = 16'h0000;
  logic [15:0] supply_mv = 16'h2EE0;
  logic [15:0] mv;
  logic        button_n = 1'b1;
  logic [7:0]  ext_low = 8'h00;
  logic [7:0]  port_in;
  logic [7:0]  port_out;
  logic [7:0]  port_oe_n;
  logic [1:0]  od_out;
  logic [1:0]  od_oe_n;
  logic [3:0]  sensor_type;
  logic [1:0]  servo_en;
  logic [1:0]  led_servo;
  logic [1:0]  led_alarm;
  logic        led_press;
  logic        led_heart;
  logic        lcd_large;
  logic [2:0]  lcd_page;
  logic        irq;
  logic        v;
  int          n;
  int          bad_count = 0;
  int          compares = 0;

  always #12.5 hclk = ~hclk;

  temp_controller_supervisor #(.SEC_TICKS(SEC), .HB_TICKS(HB)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .temp1, .temp2, .temp3, .temp4, .ain1, .ain2, .amp_temp1,
    .amp_temp2, .servo_ma1, .servo_ma2, .supply_mv, .button_n, .port_in, .port_out, .port_oe_n,
    .od_out, .od_oe_n, .sensor_type, .servo_en, .led_servo, .led_alarm, .led_press, .led_heart,
    .lcd_large, .lcd_page, .irq
  );

  pin_model pins (.port_oe_n(port_oe_n), .ext_low(ext_low), .port_in(port_in));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // hready is sampled at the negedge: it only moves after rising edges
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge hclk);
    bad_count++;
    summarize();
  end

  initial begin
    cyc(1);
    chk("rst od_oe_n", 32'h3, {30'h0, od_oe_n});
    chk("rst servo_en", 32'h0, {30'h0, servo_en});
    chk("rst port_oe_n", {24'h0, `PORT_RST}, {24'h0, port_oe_n});
    chk("tied outputs", 32'h0, {21'h0, hresp, port_out, od_out});
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wr(8'h48, 32'hFFFFFFFF);
    rd(8'h48);
    chk("unmapped", 32'h0, q);
    wr(`A_SENSOR, 32'hA);
    rd(`A_SENSOR);
    chk("sensor reg", 32'hA, q);
    chk("sensor_type", 32'hA, {28'h0, sensor_type});
    rd(`A_TEMP12);
    chk("temp12", {temp2, temp1}, q);
    rd(`A_TEMP34);
    chk("temp34", {temp4, 4'h0, temp3, 4'h0}, q);
    rd(`A_ANALOG);
    mv = 16'h05DC; // an eighth of the 12 V range
    chk("ain2 volts", {16'h0, mv}, {16'h0, q[31:16]});
    chk("ain1 volts", 32'h1, {31'h0, q[15:0] >= 16'h2ED6 && q[15:0] <= `AIN_FS_MV});
    // quasi-bidirectional port: low drives, ones read the pin
    wr(`A_PORT, 32'h0F);
    @(posedge hclk) ext_low <= 8'h08;
    cyc(4);
    chk("port_oe_n", 32'h0F, {24'h0, port_oe_n});
    rd(`A_PORT);
    chk("port read", 32'h07, {24'h0, q[7:0]});
    wr(`A_ODCTRL, {28'h0, tcs_pkg::OD_RSV, tcs_pkg::OD_LOW});
    cyc(1);
    chk("od low", 32'h2, {30'h0, od_oe_n});
    wr(`A_ODTIME1, 32'h2);
    wr(`A_ODCTRL, {26'h0, 2'b10, tcs_pkg::OD_PULSE, tcs_pkg::OD_HIGH});
    cyc(1);
    chk("pulse on", 32'h1, {30'h0, od_oe_n});
    cyc(TK - 10);
    chk("pulse held", 32'h1, {30'h0, od_oe_n});
    cyc(2 * TK + 20);
    chk("pulse end", 32'h3, {30'h0, od_oe_n});
    wr(`A_IRQMASK, 32'h7F);
    wr(`A_CTRL, 32'h3);
    cyc(1);
    chk("servo on", 32'h3, {30'h0, servo_en});
    @(posedge hclk) supply_mv <= `OV_MV + 16'h1;
    cyc(3);
    @(posedge hclk) supply_mv <= 16'h2EE0;
    cyc(3);
    chk("ov trip", 32'h0, {30'h0, servo_en});
    chk("irq ov", 32'h1, {31'h0, irq});
    rd(`A_STATUS);
    chk("ov flag", 32'h1, {26'h0, q[5:0]});
    wr(`A_IRQMASK, 32'h0);
    cyc(1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`A_IRQMASK, 32'h7F);
    wr(`A_CTRL, 32'h3);
    wr(`A_IRQSTAT, 32'h7F);
    cyc(1);
    chk("re-enable", 32'h3, {30'h0, servo_en});
    chk("irq clear", 32'h0, {31'h0, irq});
    // servo 2 sits exactly on the current limit and must stay on
    @(posedge hclk) servo_ma1 <= `OC_MA + 16'h1;
    servo_ma2 <= `OC_MA;
    cyc(TK + 10);
    chk("oc trip", 32'h2, {30'h0, servo_en});
    @(posedge hclk) servo_ma1 <= 16'h0;
    wr(`A_CTRL, 32'h3);
    @(posedge hclk) amp_temp2 <= `AMP_MAX + 16'h1;
    cyc(SEC * TK + 10);
    chk("amp trip", 32'h0, {30'h0, servo_en});
    rd(`A_AMP);
    chk("amp readable", {amp_temp2, amp_temp1}, q);
    @(posedge hclk) amp_temp2 <= 16'h7530;
    wr(`A_CTRL, 32'h3);
    wr(`A_LIMIT, {temp2 - 16'h1, 16'hFFFF});
    wr(`A_LIMIT, 32'hFFFFFFFF);
    cyc(1);
    chk("limit trip", 32'h1, {30'h0, servo_en});
    wr(`A_CTRL, 32'h0603);
    wr(`A_ALARM, {16'hFFFF, temp1 - 16'h1});
    wr(`A_PLIMIT, 32'h0);
    rd(`A_PRESS);
    chk("press A", {16'h0, mv * `GAUGE_G0}, q);
    cyc(2);
    chk("alarm led", 32'h1, {30'h0, led_alarm});
    chk("press led", 32'h1, {31'h0, led_press});
    wr(`A_PLIMIT, 32'hFFFFFFFF);
    wr(`A_CTRL, 32'h0703);
    rd(`A_PRESS);
    chk("press B", {16'h0, mv * `GAUGE_G1}, q);
    chk("press led off", 32'h0, {31'h0, led_press});
    // servo 1 on set point stays lit, servo 2 far off follows the heartbeat
    wr(`A_SETPT, {16'h0, temp1});
    v = led_heart;
    for (n = 0; n < 3 * HB * TK && led_heart === v; n++) @(negedge hclk);
    for (n = 0; n < 3 * HB * TK && led_heart !== v; n++) @(negedge hclk);
    chk("heart half", HB * TK, n);
    cyc(2);
    chk("servo led a", {30'h0, v, 1'b1}, {30'h0, led_servo});
    cyc(HB * TK);
    chk("servo led b", {30'h0, ~v, 1'b1}, {30'h0, led_servo});
    chk("heart moved", {31'h0, ~v}, {31'h0, led_heart});
    wr(`A_CTRL, 32'h0707);
    cyc(HB * TK + 10);
    chk("leds off", 32'h0, {25'h0, led_servo, led_alarm, led_press, led_heart});
    wr(`A_CTRL, 32'h077B);
    cyc(2);
    chk("page set", 32'hF, {28'h0, lcd_large, lcd_page});
    // old trip flags would hide the button event on irq
    wr(`A_IRQSTAT, 32'h7F);
    cyc(1);
    chk("irq quiet", 32'h0, {31'h0, irq});
    @(posedge hclk) button_n <= 1'b0;
    cyc(6);
    @(posedge hclk) button_n <= 1'b1;
    cyc(2);
    chk("page wrap", 32'h8, {28'h0, lcd_large, lcd_page});
    chk("irq button", 32'h1, {31'h0, irq});
    rd(`A_IRQSTAT);
    chk("button flag", 32'h40, q);
    summarize();
  end
endmodule
